// *** rtl/rch_consts.svh ***
`ifndef RCH_CONSTS_SVH
`define RCH_CONSTS_SVH
// ==========================================================
// timing
`define RCH_CLK_MHZ 200
`define RCH_MS_CYCLES (`RCH_CLK_MHZ * 1000)
// ==========================================================
// reset values
`define RCH_BACKOFF_RST 8'h00
`define RCH_TICK_RST 18'h00000
`define RCH_RETRY_RST 8'h00
`endif

// *** rtl/rch_pkg.sv ***
package rch_pkg;
	// ======================================================
	// line enables and polarities (1 = active high)
	typedef struct packed {
		logic holdoff_en;
		logic holdoff_high;
		logic req_en;
		logic req_high;
		logic req_shared;
		logic grant_en;
		logic grant_high;
		logic prio_en;
		logic prio_high;
	} rch_lines_t;
	// ======================================================
	// behaviour options
	typedef struct packed {
		logic tx_high_prio;
		logic rx_high_prio;
		logic retry_en;
		logic retry_high_prio;
		logic abort_on_loss;
		logic ack_suppress;
		logic [7:0] retry_ms;
		logic [7:0] backoff_mask;
	} rch_opts_t;
	// ======================================================
	// exchange states
	typedef enum logic [6:0] {
		RCH_IDLE = 7'h01,
		RCH_BACKOFF = 7'h02,
		RCH_WAIT = 7'h04,
		RCH_TX_SW = 7'h08,
		RCH_TX = 7'h10,
		RCH_RX_SW = 7'h20,
		RCH_ACK = 7'h40
	} rch_state_t;
endpackage

// *** rtl/rch_handshake.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rch_consts.svh"
// Overview of operation
// - request line is a push-pull output, active high in three-wire use
// - grant input is active low in three-wire use
// - priority is an active-high output, high means high priority
// - request and priority are asserted before a transmission
// - transmit starts only after cca passes and grant is seen
// - on transmit start, drop rx enable, then raise tx enable
// - after the frame, drop tx enable, raise rx enable, await ack
// - received ack completes the transmit exchange
// - after completion priority and request are dropped
// - request backoff mask is configurable 0 to 255
// - optional high priority on receive retry; retry timeout 0-255 ms
// - with abort enabled, grant loss stops transmission mid packet
// - with suppression, no ack sent without grant, under holdoff, unsecured
// - each line individually enabled and polarity configurable
// - shared request mode: several radios drive one request line
// - enabled holdoff input blocks exchange start, transmit start and the rx_active request, but not the retry_on request, while asserted
// - priority follows traffic direction: tx_high_prio during an exchange, rx options on receive
module rch_handshake (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire rch_pkg::rch_lines_t lines, // line enables and polarity
	input wire rch_pkg::rch_opts_t opts, // behaviour options
	input wire logic [7:0] rand_in, // random source for backoff
	input wire logic tx_start, // pulse: frame ready to send
	input wire logic cca_done, // pulse: cca finished
	input wire logic cca_pass, // cca result with cca_done
	input wire logic tx_done, // pulse: last bit sent
	input wire logic ack_rx, // pulse: ack frame received
	input wire logic ack_timeout, // pulse: ack wait expired
	input wire logic rx_active, // receive in progress
	input wire logic rx_retry, // pulse: receive retry requested
	input wire logic ack_want, // pulse: an ack is to be sent
	input wire logic grant_low_in, // grant line from arbiter
	input wire logic radio_holdoff_in, // holdoff line from arbiter
	input wire logic req_in, // shared request line as read back
	output logic req_out, // request line level
	output logic req_oe, // request drive enable
	output logic prio_out, // priority line level
	output logic fem_tx_active, // front-end tx enable
	output logic fem_rx_active, // front-end rx enable
	output logic cca_start, // pulse: begin cca
	output logic tx_go, // pulse: begin sending frame
	output logic tx_abort, // pulse: transmit aborted
	output logic tx_ok, // pulse: exchange completed
	output logic ack_send, // pulse: ack may be sent
	output logic ack_block, // pulse: ack suppressed
	output logic busy // exchange in progress
);
	rch_pkg::rch_state_t state;
	rch_pkg::rch_state_t next_state;
	logic [7:0] backoff;
	logic [17:0] ms_tick;
	logic [7:0] retry_left;
	logic retry_on;
	logic req_int;
	logic prio_int;
	logic granted;
	logic held_off;
	logic secured;

	// ======================================================
	// line decode
	// grant polarity
	assign granted = !lines.grant_en ||
		(lines.grant_high ? grant_low_in : !grant_low_in);
	assign held_off = lines.holdoff_en &&
		(lines.holdoff_high ? radio_holdoff_in : !radio_holdoff_in);
	// shared line secured when it reads our asserted level
	assign secured = !lines.req_shared || (req_in == lines.req_high);

	// ======================================================
	// exchange sequencing
	always_comb begin
		next_state = state;
		case (state)
			rch_pkg::RCH_IDLE: begin
				if (tx_start && !held_off)
					next_state = rch_pkg::RCH_BACKOFF;
			end
			rch_pkg::RCH_BACKOFF: begin
				if (backoff == 8'h00)
					next_state = rch_pkg::RCH_WAIT;
			end
			rch_pkg::RCH_WAIT: begin
				if (cca_done && cca_pass && granted && secured && !held_off)
					next_state = rch_pkg::RCH_TX_SW;
				else if (cca_done)
					next_state = rch_pkg::RCH_IDLE;
			end
			rch_pkg::RCH_TX_SW: next_state = rch_pkg::RCH_TX;
			rch_pkg::RCH_TX: begin
				if (opts.abort_on_loss && !granted)
					next_state = rch_pkg::RCH_IDLE;
				else if (tx_done)
					next_state = rch_pkg::RCH_RX_SW;
			end
			rch_pkg::RCH_RX_SW: next_state = rch_pkg::RCH_ACK;
			rch_pkg::RCH_ACK: begin
				if (ack_rx || ack_timeout)
					next_state = rch_pkg::RCH_IDLE;
			end
			default: next_state = rch_pkg::RCH_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			state <= rch_pkg::RCH_IDLE;
		else
			state <= next_state;
	end

	// ======================================================
	// random backoff limited by mask
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			backoff <= `RCH_BACKOFF_RST;
		else if (state == rch_pkg::RCH_IDLE)
			backoff <= rand_in & opts.backoff_mask;
		else if (state == rch_pkg::RCH_BACKOFF && backoff != 8'h00)
			backoff <= backoff - 8'h01;
	end

	// ======================================================
	// receive retry window in milliseconds
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ms_tick <= `RCH_TICK_RST;
			retry_left <= `RCH_RETRY_RST;
			retry_on <= 1'b0;
		end else if (rx_retry && opts.retry_en) begin
			ms_tick <= `RCH_TICK_RST;
			retry_left <= opts.retry_ms;
			retry_on <= (opts.retry_ms != 8'h00);
		end else if (retry_on) begin
			if (ms_tick == 18'(`RCH_MS_CYCLES - 1)) begin
				ms_tick <= `RCH_TICK_RST;
				retry_left <= retry_left - 8'h01;
				if (retry_left == 8'h01)
					retry_on <= 1'b0;
			end else
				ms_tick <= ms_tick + 18'h00001;
		end
	end

	// ======================================================
	// request and priority intent
	always_comb begin
		// held from backoff through ack wait
		req_int = (state != rch_pkg::RCH_IDLE) ||
			(rx_active && !held_off) || retry_on;
		if (state != rch_pkg::RCH_IDLE)
			prio_int = opts.tx_high_prio;
		else if (retry_on)
			prio_int = opts.rx_high_prio || opts.retry_high_prio;
		else
			prio_int = opts.rx_high_prio && rx_active;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_out <= 1'b0;
			req_oe <= 1'b0;
			prio_out <= 1'b0;
		end else begin
			req_out <= lines.req_high ? req_int : !req_int;
			// shared line: drive only the asserted level
			req_oe <= lines.req_en && (!lines.req_shared || req_int);
			prio_out <= lines.prio_en &&
				(lines.prio_high ? prio_int : !prio_int);
		end
	end

	// ======================================================
	// front-end enables, break before make
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fem_tx_active <= 1'b0;
			fem_rx_active <= 1'b0;
		end else begin
			fem_tx_active <= (next_state == rch_pkg::RCH_TX) &&
				(state == rch_pkg::RCH_TX_SW || state == rch_pkg::RCH_TX);
			fem_rx_active <= (next_state == rch_pkg::RCH_ACK) ||
				(next_state == rch_pkg::RCH_IDLE && rx_active) ||
				(next_state == rch_pkg::RCH_WAIT);
		end
	end

	// ======================================================
	// event pulses and busy level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cca_start <= 1'b0;
			tx_go <= 1'b0;
			tx_abort <= 1'b0;
			tx_ok <= 1'b0;
			busy <= 1'b0;
		end else begin
			cca_start <= state == rch_pkg::RCH_BACKOFF &&
				next_state == rch_pkg::RCH_WAIT;
			tx_go <= state == rch_pkg::RCH_TX_SW;
			tx_abort <= state == rch_pkg::RCH_TX &&
				next_state == rch_pkg::RCH_IDLE;
			tx_ok <= state == rch_pkg::RCH_ACK && ack_rx;
			busy <= next_state != rch_pkg::RCH_IDLE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_send <= 1'b0;
			ack_block <= 1'b0;
		end else begin
			ack_send <= ack_want && !(opts.ack_suppress &&
				(!granted || held_off || !secured));
			ack_block <= ack_want && opts.ack_suppress &&
				(!granted || held_off || !secured);
		end
	end
endmodule // rch_handshake
`default_nettype wire

// *** test/rch_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// handshake checker
module rch_checker (
	input wire logic clk, // clock
	input wire logic nrst, // reset
	input wire rch_pkg::rch_lines_t lines, // line config
	input wire rch_pkg::rch_opts_t opts, // options
	input wire logic tx_start, // start
	input wire logic tx_done, // sent
	input wire logic cca_done, // cca end
	input wire logic cca_pass, // cca result
	input wire logic ack_rx, // ack seen
	input wire logic grant_low_in, // grant pin
	input wire logic req_out, // request
	input wire logic prio_out, // priority
	input wire logic fem_tx_active, // tx enable
	input wire logic fem_rx_active, // rx enable
	input wire logic tx_abort, // abort
	input wire logic tx_ok, // done
	input wire logic busy // busy
);
	logic gnt;
	// grant at its active level
	assign gnt = (grant_low_in == lines.grant_high);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	start_req_a: assert property (
		tx_start && !busy && !lines.holdoff_en |=>
		busy ##1 req_out == lines.req_high) else $error("no request");
	go_grant_a: assert property (
		$rose(fem_tx_active) |-> $past(cca_done && cca_pass && gnt, 2))
		else $error("tx without cca or grant");
	rx_first_a: assert property (
		$rose(fem_tx_active) |-> !fem_rx_active && $past(!fem_rx_active))
		else $error("rx not dropped first");
	tx_rx_swap_a: assert property (
		tx_done && fem_tx_active |=> !fem_tx_active ##1 fem_rx_active)
		else $error("bad swap after frame");
	ack_done_a: assert property (tx_ok |-> $past(ack_rx))
		else $error("done without ack");
	lines_drop_a: assert property (
		tx_ok |=> req_out != lines.req_high && prio_out != lines.prio_high)
		else $error("lines not dropped");
	req_held_a: assert property (
		busy && $past(busy) |-> req_out == lines.req_high)
		else $error("request gap");
	prio_static_a: assert property (
		busy && $past(busy) && $past(busy, 2) |-> $stable(prio_out))
		else $error("prio moved");
	abort_loss_a: assert property (
		$fell(gnt) && fem_tx_active && opts.abort_on_loss |-> ##[0:3] tx_abort)
		else $error("no abort");
	cover property (tx_ok);
	cover property (tx_abort);
	cover property ($rose(fem_tx_active));
endmodule // rch_checker
bind rch_handshake rch_checker chk (.clk(clk), .nrst(nrst), .lines(lines),
	.opts(opts), .tx_start(tx_start), .tx_done(tx_done),
	.cca_done(cca_done), .cca_pass(cca_pass), .ack_rx(ack_rx),
	.grant_low_in(grant_low_in), .req_out(req_out), .prio_out(prio_out),
	.fem_tx_active(fem_tx_active), .fem_rx_active(fem_rx_active),
	.tx_abort(tx_abort), .tx_ok(tx_ok), .busy(busy));
`default_nettype wire

// *** test/rch_arbiter.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// wlan arbiter model
module rch_arbiter (
	input wire logic clk, // clock
	input wire logic nrst, // reset
	input wire logic req_line, // request, active high
	input wire logic prio_line, // priority, active high
	input wire logic deny, // bench forces grant loss
	output logic grant_low, // grant, active low
	output logic wlan_tx_active // wlan transmitting
);
	logic [1:0] dly;
	// grant after a delay, drop once request goes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dly <= 2'h0;
			grant_low <= 1'h1;
		end else begin
			dly <= req_line ? {dly[0], 1'h1} : 2'h0;
			grant_low <= !(req_line && dly == 2'h3 && !deny);
		end
	end
	// high priority request pre-empts wlan traffic
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			wlan_tx_active <= 1'h1;
		else
			wlan_tx_active <= !(req_line && prio_line);
	end
endmodule // rch_arbiter
`default_nettype wire

// *** test/rch_handshake_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench
module rch_handshake_tb;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	rch_pkg::rch_lines_t lines = 9'h0EB;
	rch_pkg::rch_opts_t opts = 22'h23100F;
	logic [7:0] rand_in = 8'h00;
	logic tx_start = 1'h0, cca_done = 1'h0, cca_pass = 1'h0, tx_done = 1'h0;
	logic ack_rx = 1'h0, ack_want = 1'h0, hold = 1'h0, deny = 1'h0;
	logic gnt_n, req_out, prio_out, tx_a, rx_a, cca_start, tx_go, tx_abort;
	logic tx_ok, ack_send, ack_block, busy;
	logic [3:0] got = 4'h0;
	int fail_count = 0, comparisons = 0, cyc = 0, n = 0;
	// rows: {abort, cca pass, rand}
	logic [9:0] rows [4] = '{10'h100, 10'h11B, 10'h003, 10'h305};
	always #2.5 clk = ~clk;
	rch_handshake uut (.clk(clk), .nrst(nrst), .lines(lines), .opts(opts),
		.rand_in(rand_in), .tx_start(tx_start), .cca_done(cca_done),
		.cca_pass(cca_pass), .tx_done(tx_done), .ack_rx(ack_rx),
		.ack_timeout(1'h0), .rx_active(1'h0), .rx_retry(1'h0),
		.ack_want(ack_want), .grant_low_in(gnt_n), .radio_holdoff_in(hold),
		.req_in(req_out), .req_out(req_out), .req_oe(), .prio_out(prio_out),
		.fem_tx_active(tx_a), .fem_rx_active(rx_a), .cca_start(cca_start),
		.tx_go(tx_go), .tx_abort(tx_abort), .tx_ok(tx_ok),
		.ack_send(ack_send), .ack_block(ack_block), .busy(busy));
	rch_arbiter arb (.clk(clk), .nrst(nrst), .req_line(req_out),
		.prio_line(prio_out), .deny(deny), .grant_low(gnt_n),
		.wlan_tx_active());
	// collect pulses between checks
	always @(negedge clk) got <= got | {ack_send, ack_block, tx_abort, tx_ok};
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one exchange, optionally failing cca or losing grant in tx
	task automatic run(input logic [9:0] r);
		@(posedge clk);
		rand_in <= r[7:0];
		tx_start <= 1'h1;
		got = 4'h0;
		@(posedge clk);
		tx_start <= 1'h0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!cca_start && n < 300);
		chk(n[7:0], 8'h02 + (r[7:0] & opts.backoff_mask));
		chk({req_out, prio_out}, 8'h03);
		while (gnt_n && n < 300) @(negedge clk) n++;
		@(posedge clk);
		cca_done <= 1'h1;
		cca_pass <= r[8];
		@(posedge clk);
		cca_done <= 1'h0;
		repeat (2) @(negedge clk);
		chk({tx_go, tx_a}, {2{r[8]}});
		@(posedge clk);
		deny <= r[9];
		tx_done <= r[8] && !r[9];
		@(posedge clk);
		tx_done <= 1'h0;
		repeat (2) @(posedge clk);
		ack_rx <= r[8] && !r[9];
		@(posedge clk);
		ack_rx <= 1'h0;
		deny <= 1'h0;
		repeat (3) @(negedge clk);
		chk(got, {2'h0, r[9], r[8] && !r[9]});
		chk({busy, req_out, prio_out}, 8'h00);
	endtask
	// cycle ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			end_sim;
		end
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		chk({req_out, prio_out, tx_a, rx_a, busy}, 8'h00);
		nrst <= 1'h1;
		foreach (rows[i]) run(rows[i]);
		@(posedge clk);
		lines.holdoff_en <= 1'h1;
		hold <= 1'h1;
		tx_start <= 1'h1;
		got = 4'h0;
		@(posedge clk);
		tx_start <= 1'h0;
		ack_want <= 1'h1;
		@(posedge clk);
		ack_want <= 1'h0;
		repeat (4) @(negedge clk);
		chk({busy, got}, 8'h04);
		@(posedge clk);
		hold <= 1'h0;
		opts.ack_suppress <= 1'h0;
		ack_want <= 1'h1;
		got = 4'h0;
		@(posedge clk);
		ack_want <= 1'h0;
		repeat (2) @(negedge clk);
		chk(got, 8'h08);
		end_sim;
	end
endmodule // rch_handshake_tb
`default_nettype wire
